// file: include/sfwp_pkg.sv
// Constants and types for the flash protection and status command block
// How it works
// - Opcodes enter and leave the secured area mode; neither carries address bytes.
// - Security read returns the register; security write sets a permanent lock-down bit.
// - Identification read: address byte zero sends maker code first, one sends device code.
// - Completing the latch set command sets the write latch bit.
// - Completing the latch clear command clears the write latch bit.
// - Latch clears at power-up and when clear, status write, program, erase complete.
// - Status read is accepted any time, even busy, and repeats while clocked.
// - Status bit 0 is a busy flag, one during program, erase or status write.
// - Status bit 1 is the write latch; zero refuses program, erase, status write.
// - Program or erase aimed at a protected area is ignored, latch unchanged.
// - Status bits 5 to 2 are protect level bits, changed only by status write.
// - Chip erase runs only when all four protect level bits are zero.
// - Lock bit set with protect pin low: status writes refused, bits read-only.
// - Status write leaves bits 6, 1 and 0 alone; updates lock and levels.
// - Chip select must rise on a byte boundary, else the command is dropped.
// - Valid status write starts a timed busy cycle, then clears busy and latch.
package sfwp_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS          = 40;
  localparam int STATUS_WRITE_TIME_NS   = 5000;
  localparam int PROGRAM_TIME_NS        = 20000;
  localparam int ERASE_TIME_NS          = 40000;
  localparam int SW_CYC_INT = (STATUS_WRITE_TIME_NS / CLK_PERIOD_NS < 1) ? 1 :
                              STATUS_WRITE_TIME_NS / CLK_PERIOD_NS;
  localparam int PP_CYC_INT = (PROGRAM_TIME_NS / CLK_PERIOD_NS < 1) ? 1 :
                              PROGRAM_TIME_NS / CLK_PERIOD_NS;
  localparam int ER_CYC_INT = (ERASE_TIME_NS / CLK_PERIOD_NS < 1) ? 1 :
                              ERASE_TIME_NS / CLK_PERIOD_NS;
  localparam logic [15:0] STATUS_WRITE_CYC = 16'(SW_CYC_INT);
  localparam logic [15:0] PROGRAM_CYC      = 16'(PP_CYC_INT);
  localparam logic [15:0] ERASE_CYC        = 16'(ER_CYC_INT);
  localparam logic [15:0] BUSY_LAST        = 16'h0001;
  localparam logic [15:0] BUSY_NONE        = 16'h0000;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_LATCH_SET    = 8'h06;
  localparam logic [7:0] OP_LATCH_CLEAR  = 8'h04;
  localparam logic [7:0] OP_STATUS_READ  = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_BLOCK_ERASE1 = 8'h52;
  localparam logic [7:0] OP_BLOCK_ERASE2 = 8'hD8;
  localparam logic [7:0] OP_CHIP_ERASE1  = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE2  = 8'hC7;
  localparam logic [7:0] OP_ID_READ      = 8'h90;
  localparam logic [7:0] OP_SEC_READ     = 8'h2B;
  localparam logic [7:0] OP_SEC_WRITE    = 8'h2F;
  localparam logic [7:0] OP_AREA_ENTER   = 8'hB1;
  localparam logic [7:0] OP_AREA_LEAVE   = 8'hC1;

  // ----------------------------------------------------------------
  // Frame lengths in whole bytes, opcode included
  // ----------------------------------------------------------------
  localparam logic [2:0] NB_OPCODE_ONLY  = 3'h1;
  localparam logic [2:0] NB_STATUS_WRITE = 3'h2;
  localparam logic [2:0] NB_ID_ADD_POS   = 3'h3;
  localparam logic [2:0] NB_ADDR_CMD     = 3'h4;
  localparam logic [2:0] NB_PROGRAM_MIN  = 3'h5;
  localparam logic [2:0] NB_SAT          = 3'h7;
  localparam logic [2:0] BIT_LAST        = 3'h7;
  localparam logic [2:0] BIT_FIRST       = 3'h0;

  // ----------------------------------------------------------------
  // Status and security fields, reset values, identity
  // ----------------------------------------------------------------
  localparam int STS_LOCK_BIT  = 7;
  localparam int STS_ZERO_BIT  = 6;
  localparam int STS_LVL_MSB   = 5;
  localparam int STS_LVL_LSB   = 2;
  localparam logic [3:0] LEVEL_RESET = 4'h0;
  localparam logic [3:0] LEVEL_NONE  = 4'h0;
  localparam logic       LOCK_RESET  = 1'b0;
  localparam logic       FACTORY_LOCKED = 1'b1;
  localparam logic [5:0] SEC_PAD     = 6'h00;
  localparam logic [7:0] ID_ADD_DEV_FIRST_MASK = 8'h01;
  // Arbitrary identity values
  localparam logic [7:0] MAKER_CODE  = 8'hA5;
  localparam logic [7:0] DEVICE_CODE = 8'h3C;

  // ----------------------------------------------------------------
  // Pins: {sclk, cs_n, mosi, wp_n}
  // ----------------------------------------------------------------
  localparam int PIN_W    = 4;
  localparam int PIN_SCLK = 3;
  localparam int PIN_CSN  = 2;
  localparam int PIN_MOSI = 1;
  localparam int PIN_WPN  = 0;
  localparam logic [3:0] PIN_IDLE = 4'h5;

  typedef enum logic [3:0] {
    SF_IDLE = 4'h1,
    SF_OPC  = 4'h2,
    SF_ARG  = 4'h4,
    SF_OUT  = 4'h8
  } sfwp_state_type;

endpackage

// file: logic/sfwp_sync.sv
// Two-stage synchroniser for the serial link pins
`timescale 1ns/1ns
`default_nettype none
module sfwp_sync
  import sfwp_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic [PIN_W-1:0] pin_in,
  output var  logic [PIN_W-1:0] pin_sync
);

  logic [PIN_W-1:0] meta_q;
  logic [PIN_W-1:0] meta_d;
  logic [PIN_W-1:0] sync_d;

  // Second stage is the only reader of the first
  always_comb begin
    meta_d = pin_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      meta_q   <= PIN_IDLE;
      pin_sync <= PIN_IDLE;
    end else begin
      meta_q   <= meta_d;
      pin_sync <= sync_d;
    end
  end

endmodule
`default_nettype wire

// file: logic/sfwp_top.sv
// Command decoder, status register and write protection of the serial flash
`timescale 1ns/1ns
`default_nettype none
module sfwp_top
  import sfwp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       mosi,
  input  wire logic       wp_n,
  output var  logic       miso,
  output var  logic       miso_oe,
  output var  logic       busy_flag,
  output var  logic       write_latch_bit,
  output var  logic [3:0] protect_level_bits,
  output var  logic       status_lock_bit,
  output var  logic       hardware_protect_state,
  output var  logic       secure_area_mode
);

  // ----------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------
  logic [PIN_W-1:0] pins;

  sfwp_sync u_sync (
    .clk      (clk),
    .nrst     (nrst),
    .pin_in   ({sclk, cs_n, mosi, wp_n}),
    .pin_sync (pins)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  sfwp_state_type state_q, state_d;
  logic [7:0]  op_q, op_d;
  logic [7:0]  rx_q, rx_d;
  logic [7:0]  tx_q, tx_d;
  logic [2:0]  bit_q, bit_d;
  logic [2:0]  bytes_q, bytes_d;
  logic        id_dev_q, id_dev_d;
  logic        sclk_prev_q, sclk_prev_d;
  logic        csn_prev_q, csn_prev_d;
  logic [15:0] busy_cnt_q, busy_cnt_d;
  logic        busy_q, busy_d;
  logic        wel_q, wel_d;
  logic [3:0]  level_q, level_d;
  logic        lock_q, lock_d;
  logic        hwp_q, hwp_d;
  logic        sec_lock_q, sec_lock_d;
  logic        area_q, area_d;
  logic        miso_q, miso_d;
  logic        oe_q, oe_d;

  logic       sclk_rise, sclk_fall, cs_rise, cs_fall;
  logic [7:0] rx_byte, status_byte, sec_byte, id_first;
  logic       frame_ok, latch_set_cmd_go, latch_clear_cmd_go, sw_go, ce_go, er_try, pp_try;
  logic       er_go, pp_go, sec_go, ens_go, exs_go, area_prot;

  // ----------------------------------------------------------------
  // Decode of a finished frame
  // ----------------------------------------------------------------
  always_comb begin
    sclk_rise   = pins[PIN_SCLK] & ~sclk_prev_q;
    sclk_fall   = ~pins[PIN_SCLK] & sclk_prev_q;
    cs_rise     = pins[PIN_CSN] & ~csn_prev_q;
    cs_fall     = ~pins[PIN_CSN] & csn_prev_q;
    rx_byte     = {rx_q[6:0], pins[PIN_MOSI]};
    status_byte = {lock_q, 1'b0, level_q, wel_q, busy_q};
    sec_byte    = {SEC_PAD, sec_lock_q, FACTORY_LOCKED};
    id_first    = ((rx_byte & ID_ADD_DEV_FIRST_MASK) != 8'h00) ? DEVICE_CODE
                                                               : MAKER_CODE;
    // No area table here: any nonzero level shields the whole array
    area_prot   = (level_q != LEVEL_NONE);
    // Torn frames and frames during a write cycle are dropped
    frame_ok = cs_rise && (bit_q == BIT_FIRST) && !busy_q;
    latch_set_cmd_go  = frame_ok && (op_q == OP_LATCH_SET) && (bytes_q == NB_OPCODE_ONLY);
    latch_clear_cmd_go  = frame_ok && (op_q == OP_LATCH_CLEAR) && (bytes_q == NB_OPCODE_ONLY);
    sw_go    = frame_ok && (op_q == OP_STATUS_WRITE) && (bytes_q == NB_STATUS_WRITE)
               && wel_q && !hwp_q;
    ce_go    = frame_ok && ((op_q == OP_CHIP_ERASE1) || (op_q == OP_CHIP_ERASE2))
               && (bytes_q == NB_OPCODE_ONLY) && wel_q
               && (level_q == LEVEL_NONE);
    er_try   = frame_ok && ((op_q == OP_SECTOR_ERASE) || (op_q == OP_BLOCK_ERASE1)
               || (op_q == OP_BLOCK_ERASE2)) && (bytes_q == NB_ADDR_CMD) && wel_q;
    pp_try   = frame_ok && (op_q == OP_PAGE_PROGRAM) && (bytes_q >= NB_PROGRAM_MIN)
               && wel_q;
    er_go    = er_try && !area_prot;
    pp_go    = pp_try && !area_prot;
    sec_go   = frame_ok && (op_q == OP_SEC_WRITE) && (bytes_q == NB_OPCODE_ONLY);
    ens_go   = frame_ok && (op_q == OP_AREA_ENTER) && (bytes_q == NB_OPCODE_ONLY);
    exs_go   = frame_ok && (op_q == OP_AREA_LEAVE) && (bytes_q == NB_OPCODE_ONLY);
  end

  // ----------------------------------------------------------------
  // Next values
  // ----------------------------------------------------------------
  always_comb begin
    state_d     = state_q;
    op_d        = op_q;
    rx_d        = rx_q;
    tx_d        = tx_q;
    bit_d       = bit_q;
    bytes_d     = bytes_q;
    id_dev_d    = id_dev_q;
    sclk_prev_d = pins[PIN_SCLK];
    csn_prev_d  = pins[PIN_CSN];
    hwp_d       = lock_q & ~pins[PIN_WPN];
    busy_cnt_d  = busy_cnt_q;
    wel_d       = wel_q;
    level_d     = level_q;
    lock_d      = lock_q;
    sec_lock_d  = sec_lock_q;
    area_d      = area_q;
    miso_d      = miso_q;
    oe_d        = oe_q;

    // Self-timed cycle; its end releases the latch
    if (busy_cnt_q != BUSY_NONE) begin
      busy_cnt_d = busy_cnt_q - BUSY_LAST;
      if (busy_cnt_q == BUSY_LAST) begin
        wel_d = 1'b0;
      end
    end

    if (pins[PIN_CSN]) begin
      state_d = SF_IDLE;
      bit_d   = BIT_FIRST;
      bytes_d = 3'h0;
      oe_d    = 1'b0;
      if (latch_set_cmd_go) begin
        wel_d = 1'b1;
      end
      if (latch_clear_cmd_go) begin
        wel_d = 1'b0;
      end
      if (sw_go) begin
        // Bits 6, 1 and 0 are not taken from the data byte
        lock_d     = rx_q[STS_LOCK_BIT];
        level_d    = rx_q[STS_LVL_MSB:STS_LVL_LSB];
        busy_cnt_d = STATUS_WRITE_CYC;
      end
      if (ce_go || er_go) begin
        busy_cnt_d = ERASE_CYC;
      end
      if (pp_go) begin
        busy_cnt_d = PROGRAM_CYC;
      end
      if (sec_go) begin
        sec_lock_d = 1'b1;
      end
      if (ens_go) begin
        area_d = 1'b1;
      end
      if (exs_go) begin
        area_d = 1'b0;
      end
    end else begin
      if (cs_fall) begin
        state_d = SF_OPC;
      end
      if (sclk_rise && (state_q != SF_IDLE)) begin
        rx_d  = rx_byte;
        bit_d = bit_q + 3'h1;
        if (bit_q == BIT_LAST) begin
          if (bytes_q != NB_SAT) begin
            bytes_d = bytes_q + 3'h1;
          end
          unique case (state_q)
            SF_OPC: begin
              op_d    = rx_byte;
              state_d = SF_ARG;
              if (rx_byte == OP_STATUS_READ) begin
                state_d = SF_OUT;
                tx_d    = status_byte;
              end else if ((rx_byte == OP_SEC_READ) && !busy_q) begin
                state_d = SF_OUT;
                tx_d    = sec_byte;
              end
            end
            SF_ARG: begin
              if ((op_q == OP_ID_READ) && (bytes_q == NB_ID_ADD_POS) && !busy_q) begin
                state_d  = SF_OUT;
                tx_d     = id_first;
                id_dev_d = (id_first == MAKER_CODE);
              end
            end
            SF_OUT: begin
              // Each new byte reloads, so status polling stays live
              if (op_q == OP_STATUS_READ) begin
                tx_d = status_byte;
              end else if (op_q == OP_SEC_READ) begin
                tx_d = sec_byte;
              end else begin
                tx_d     = id_dev_q ? DEVICE_CODE : MAKER_CODE;
                id_dev_d = ~id_dev_q;
              end
            end
            SF_IDLE: begin
              state_d = SF_IDLE;
            end
          endcase
        end
      end
      if (sclk_fall && (state_q == SF_OUT)) begin
        miso_d = tx_q[7];
        tx_d   = {tx_q[6:0], 1'b0};
        oe_d   = 1'b1;
      end
    end
    busy_d = (busy_cnt_d != BUSY_NONE);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q     <= SF_IDLE;
      op_q        <= 8'h00;
      rx_q        <= 8'h00;
      tx_q        <= 8'h00;
      bit_q       <= BIT_FIRST;
      bytes_q     <= 3'h0;
      id_dev_q    <= 1'b0;
      sclk_prev_q <= 1'b0;
      csn_prev_q  <= 1'b1;
      busy_cnt_q  <= BUSY_NONE;
      busy_q      <= 1'b0;
      wel_q       <= 1'b0;
      level_q     <= LEVEL_RESET;
      lock_q      <= LOCK_RESET;
      hwp_q       <= 1'b0;
      sec_lock_q  <= 1'b0;
      area_q      <= 1'b0;
      miso_q      <= 1'b0;
      oe_q        <= 1'b0;
    end else begin
      state_q     <= state_d;
      op_q        <= op_d;
      rx_q        <= rx_d;
      tx_q        <= tx_d;
      bit_q       <= bit_d;
      bytes_q     <= bytes_d;
      id_dev_q    <= id_dev_d;
      sclk_prev_q <= sclk_prev_d;
      csn_prev_q  <= csn_prev_d;
      busy_cnt_q  <= busy_cnt_d;
      busy_q      <= busy_d;
      wel_q       <= wel_d;
      level_q     <= level_d;
      lock_q      <= lock_d;
      hwp_q       <= hwp_d;
      sec_lock_q  <= sec_lock_d;
      area_q      <= area_d;
      miso_q      <= miso_d;
      oe_q        <= oe_d;
    end
  end

  always_comb begin
    miso                   = miso_q;
    miso_oe                = oe_q;
    busy_flag              = busy_q;
    write_latch_bit        = wel_q;
    protect_level_bits     = level_q;
    status_lock_bit        = lock_q;
    hardware_protect_state = hwp_q;
    secure_area_mode       = area_q;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_busy_hold;
    sw_go |=> busy_q [*8];
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");

  property p_sw_end;
    sw_go |-> ##[2:130] (!busy_q && !wel_q);
  endproperty
  a_sw_end: assert property (p_sw_end) else $error("status write never ended");

  property p_latch_set_cmd;
    latch_set_cmd_go |=> wel_q;
  endproperty
  a_latch_set_cmd: assert property (p_latch_set_cmd) else $error("latch not set");

  property p_latch_clear_cmd;
    latch_clear_cmd_go |=> !wel_q;
  endproperty
  a_latch_clear_cmd: assert property (p_latch_clear_cmd) else $error("latch not cleared");

  property p_level_only_sw;
    !sw_go |=> $stable(level_q) && $stable(lock_q);
  endproperty
  a_level_only_sw: assert property (p_level_only_sw) else $error("level moved");

  property p_hw_protect;
    (cs_rise && hwp_q && !busy_q && (op_q == OP_STATUS_WRITE)) |=> !busy_q;
  endproperty
  a_hw_protect: assert property (p_hw_protect) else $error("protected write ran");

  property p_sw_needs_latch;
    (frame_ok && !wel_q && (op_q == OP_STATUS_WRITE)) |=> !busy_q && $stable(level_q);
  endproperty
  a_sw_needs_latch: assert property (p_sw_needs_latch) else $error("write without latch");

  property p_ce_levels;
    (busy_cnt_d == ERASE_CYC) && !busy_q |-> (level_q == LEVEL_NONE) || er_go;
  endproperty
  a_ce_levels: assert property (p_ce_levels) else $error("erase under protection");

  property p_prot_keep;
    (er_try || pp_try) && area_prot |=> wel_q && !busy_q;
  endproperty
  a_prot_keep: assert property (p_prot_keep) else $error("protected op acted");

  property p_seclock;
    sec_lock_q |=> sec_lock_q;
  endproperty
  a_seclock: assert property (p_seclock) else $error("lock-down cleared");

  property p_torn;
    (cs_rise && (bit_q != BIT_FIRST) && !busy_q) |=> !busy_q && $stable(wel_q);
  endproperty
  a_torn: assert property (p_torn) else $error("torn frame acted");

endmodule
`default_nettype wire

// file: bench/sfwp_host.sv
// Host serial controller model that clocks framed command bytes into the block
`timescale 1ns/1ns
`default_nettype none
module sfwp_host (
  output var  logic sclk,
  output var  logic cs_n,
  output var  logic mosi,
  input  wire logic miso
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // ----------------------------------------------------------------
  // Mode 0 frame, link clock stands still outside frames
  // ----------------------------------------------------------------
  // Miso taken late in the high phase, well after the 2-3 clk output lag
  task automatic xfer(input int nbits, input logic [63:0] tx, output logic [63:0] rx);
    int i;
    rx = 64'h0;
    #7 cs_n = 1'b0;
    #160;
    for (i = 0; i < nbits; i++) begin
      mosi = tx[63-i];
      #160 sclk = 1'b1;
      #150 rx = {rx[62:0], miso};
      #10 sclk = 1'b0;
    end
    #160 cs_n = 1'b1;
    // Released data line must not hold its last level
    mosi = ~mosi;
    #320;
  endtask
endmodule
`default_nettype wire

// file: bench/tb.sv
// Self-checking bench for the status and write protection command block
`timescale 1ns/1ns
`default_nettype none
module tb;
  import sfwp_pkg::*;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        wp_n = 1'b1;
  logic        sclk, cs_n, mosi, miso, miso_oe, busy_flag, write_latch_bit;
  logic [3:0]  protect_level_bits;
  logic        status_lock_bit, hardware_protect_state, secure_area_mode;
  logic [63:0] rx;
  logic [15:0] busy_cnt = 16'h0000;
  logic        busy_prev = 1'b0;
  int          err_count = 0;
  int          total_checks = 0;

  always #20 clk = ~clk;
  // Restarts at each rise, so it holds the length of the last busy span
  always @(posedge clk) begin
    busy_prev <= (busy_flag === 1'b1);
    if (busy_flag === 1'b1) busy_cnt <= busy_prev ? busy_cnt + 16'h0001 : 16'h0001;
  end

  sfwp_top dut (.clk, .nrst, .sclk, .cs_n, .mosi, .wp_n, .miso, .miso_oe, .busy_flag,
    .write_latch_bit, .protect_level_bits, .status_lock_bit, .hardware_protect_state,
    .secure_area_mode);
  sfwp_host host (.sclk, .cs_n, .mosi, .miso);

  // ----------------------------------------------------------------
  // Compare and access tasks
  // ----------------------------------------------------------------
  task automatic chk_bit(input string name, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s exp %b got %b", name, exp, got);
    end
  endtask
  task automatic chk_val(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s exp %h got %h", name, exp, got);
    end
  endtask
  task automatic send(input int nbits, input logic [63:0] tx);
    host.xfer(nbits, tx, rx);
  endtask
  task automatic op(input logic [7:0] code);
    send(8, {code, 56'h0});
  endtask
  task automatic rd_byte(input logic [7:0] code, input string name, input logic [7:0] exp);
    fork
      send(16, {code, 56'h0});
      #4000 chk_bit({name, " drive"}, 1'b1, miso_oe);
    join
    chk_val(name, {8'h00, exp}, {8'h00, rx[7:0]});
    chk_bit({name, " release"}, 1'b0, miso_oe);
  endtask
  // Bounded poll, long enough for the slowest self-timed cycle
  task automatic wait_idle;
    int n;
    n = 0;
    while (busy_flag !== 1'b0 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    chk_bit("busy wait ended", 1'b0, busy_flag);
  endtask
  task automatic print_verdict;
    if (err_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #3000000;
    err_count++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    chk_val("reset state", 16'h0000, {8'h00, status_lock_bit, 1'b0, protect_level_bits,
      write_latch_bit, busy_flag});
    rd_byte(OP_STATUS_READ, "status idle", 8'h00);
    op(OP_LATCH_SET);
    chk_bit("latch set", 1'b1, write_latch_bit);
    rd_byte(OP_STATUS_READ, "status latch", 8'h02);
    op(OP_LATCH_CLEAR);
    chk_bit("latch clear", 1'b0, write_latch_bit);
    send(16, {OP_STATUS_WRITE, 8'hFC, 48'h0});
    chk_val("write without latch", 16'h0000, {12'h000, protect_level_bits});
    op(OP_LATCH_SET);
    send(16, {OP_STATUS_WRITE, 8'hFF, 48'h0});
    chk_bit("busy after write", 1'b1, busy_flag);
    rd_byte(OP_STATUS_READ, "status while busy", 8'hBF);
    wait_idle();
    chk_val("write cycle length", STATUS_WRITE_CYC, busy_cnt);
    chk_bit("latch after write", 1'b0, write_latch_bit);
    chk_val("levels written", 16'h001F, {11'h000, status_lock_bit, protect_level_bits});
    // Hardware protection refuses the write and keeps the bits
    @(negedge clk) wp_n = 1'b0;
    repeat (6) @(negedge clk);
    chk_bit("hw protect on", 1'b1, hardware_protect_state);
    op(OP_LATCH_SET);
    send(16, {OP_STATUS_WRITE, 8'h00, 48'h0});
    chk_val("hw refused", 16'h001F, {10'h000, busy_flag, status_lock_bit,
      protect_level_bits});
    @(negedge clk) wp_n = 1'b1;
    repeat (6) @(negedge clk);
    chk_bit("hw protect off", 1'b0, hardware_protect_state);
    // Protected array: erase ignored, latch kept
    op(OP_LATCH_SET);
    op(OP_CHIP_ERASE1);
    chk_val("chip erase protected", 16'h0001, {14'h0, busy_flag, write_latch_bit});
    op(OP_LATCH_SET);
    send(32, {OP_SECTOR_ERASE, 24'h001000, 32'h0});
    chk_val("sector erase protected", 16'h0001, {14'h0, busy_flag, write_latch_bit});
    op(OP_LATCH_SET);
    send(32, {OP_BLOCK_ERASE1, 24'h010000, 32'h0});
    chk_val("block erase protected", 16'h0001, {14'h0, busy_flag, write_latch_bit});
    send(12, {OP_STATUS_WRITE, 8'h00, 48'h0});
    chk_val("off-boundary write", 16'h000F, {12'h000, protect_level_bits});
    op(OP_LATCH_SET);
    send(16, {OP_STATUS_WRITE, 8'h00, 48'h0});
    wait_idle();
    chk_val("levels cleared", 16'h0000, {11'h000, status_lock_bit, protect_level_bits});
    op(OP_LATCH_SET);
    op(OP_CHIP_ERASE2);
    chk_bit("chip erase runs", 1'b1, busy_flag);
    wait_idle();
    chk_bit("latch after erase", 1'b0, write_latch_bit);
    op(OP_LATCH_SET);
    send(32, {OP_BLOCK_ERASE2, 24'h010000, 32'h0});
    chk_bit("block erase runs", 1'b1, busy_flag);
    wait_idle();
    chk_bit("latch after block erase", 1'b0, write_latch_bit);
    op(OP_LATCH_SET);
    send(40, {OP_PAGE_PROGRAM, 24'h000100, 8'h5A, 24'h0});
    wait_idle();
    chk_val("program cycle length", PROGRAM_CYC, busy_cnt);
    chk_bit("latch after program", 1'b0, write_latch_bit);
    op(OP_AREA_ENTER);
    chk_bit("area enter", 1'b1, secure_area_mode);
    op(OP_AREA_LEAVE);
    chk_bit("area leave", 1'b0, secure_area_mode);
    rd_byte(OP_SEC_READ, "security read", {SEC_PAD, 1'b0, FACTORY_LOCKED});
    op(OP_SEC_WRITE);
    op(OP_SEC_WRITE);
    rd_byte(OP_SEC_READ, "security locked", {SEC_PAD, 1'b1, FACTORY_LOCKED});
    for (int a = 0; a < 2; a++) begin
      send(48, {OP_ID_READ, 16'h0000, 8'(a), 32'h0});
      chk_val("id order", (a == 1) ? {DEVICE_CODE, MAKER_CODE} : {MAKER_CODE, DEVICE_CODE},
        rx[15:0]);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
